// File: design/miir_data_ctrl.v
// Measurement data path: calibration, first-order IIR filter per cell and block channel,
// result registers, cell sum and alert data stream, behind an APB slave.
// Assumes the sequencer runs on pclk, pulses its events for one cycle and
// writes no sample while xfer_busy is high.
`timescale 1ns/1ps
`include "miir_defs.vh"

module miir_data_ctrl (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        alu_valid,
  input  wire [4:0]  alu_ch,
  input  wire [13:0] alu_raw,
  input  wire        scan_start,
  input  wire        scan_end,
  input  wire        move_req,
  input  wire        bal_meas_done,
  output reg         xfer_busy,
  output reg         alert_valid,
  output reg  [4:0]  alert_ch,
  output reg  [13:0] alert_data
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_XFER = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg [2:0]         state;
  reg [7:0]         ctrl;
  reg [14:0]        channel_enable_cfg;
  reg               acq_filter_preload;
  reg               balance_filter_preload;
  reg               result_ready_flag;
  reg [15:0]        cal_off;
  reg               pend;
  reg [4:0]         xch;
  reg               x_load;
  reg               x_stats;
  reg               x_bal;
  reg [17:0]        sum_acc;
  reg [17:0]        cell_sum_result;
  reg [13:0]        alu_mem [0:16];
  reg [16:0]        acc     [0:14];
  reg [13:0]        res     [0:16];
  reg [31:0]        next_prdata;
  integer           i;

  wire              filter_update_en  = ctrl[`MIIR_B_UPD];
  wire              filtered_read_sel = ctrl[`MIIR_B_RDF];
  wire              alert_source_sel  = ctrl[`MIIR_B_ASRC];
  wire              double_buffer_en  = ctrl[`MIIR_B_DBL];
  wire              cal_apply_en      = ctrl[`MIIR_B_CAL];
  wire [2:0]        filter_coef_sel   = ctrl[`MIIR_B_COEF_HI:`MIIR_B_COEF_LO];

  // APB: one wait state, so every access completes in the second access cycle
  wire              acc_ph = psel & penable;
  wire              wr_en  = acc_ph & pready & pwrite;
  wire [7:0]        idx    = paddr[9:2];
  wire              hi_ok  = (paddr[11:10] == 2'b00);
  // Offset taken at full index width; the subtraction wraps for indices below the cell range, where it goes unused
  wire [7:0]        cell_off = idx - `MIIR_IDX_CELL0;

  function mapped;
    input [7:0] a;
    begin
      mapped = ((a >= `MIIR_IDX_CTRL) && (a <= `MIIR_IDX_CAL)) ||
               ((a >= `MIIR_IDX_CELL0) && (a <= `MIIR_IDX_CELL13)) ||
               ((a >= `MIIR_IDX_BLOCK) && (a <= `MIIR_IDX_DIAGB));
    end
  endfunction

  // Calibration stage: signed offset with saturation to the result range
  wire signed [17:0] cal_sum = $signed({4'h0, alu_raw}) + $signed({{2{cal_off[15]}}, cal_off});
  wire [13:0]        cal_x   = cal_sum[17] ? 14'h0000 :
                               ((cal_sum > $signed(`MIIR_RAW_MAX)) ? 14'h3FFF : cal_sum[13:0]);
  wire [13:0]        alu_in  = cal_apply_en ? cal_x : alu_raw;

  // Filter arithmetic for the channel being transferred
  wire               is_filt = (xch <= `MIIR_CH_BLK);
  wire [3:0]         fidx    = is_filt ? xch[3:0] : 4'h0;
  wire [13:0]        x_s     = alu_mem[xch];
  wire [16:0]        a_s     = acc[fidx];
  // Balancing cycles never run unfiltered
  wire [2:0]         coef    = (x_bal && (filter_coef_sel == `MIIR_COEF_OFF)) ?
                               `MIIR_COEF_BAL : filter_coef_sel;
  // Code c weights the sample by (c+1)/8
  wire [3:0]         k       = {1'b0, coef} + 4'h1;
  wire               init    = x_bal ? balance_filter_preload : acq_filter_preload;
  wire signed [17:0] diff    = $signed({1'b0, x_s, 3'b000}) - $signed({1'b0, a_s});
  wire signed [22:0] prod    = diff * $signed({1'b0, k});
  wire signed [22:0] step    = prod >>> `MIIR_FRAC;
  // Y = acc + (8x - acc)*k/8; k = 8 lands exactly on the sample
  wire [16:0]        blend   = a_s + step[16:0];
  wire [16:0]        acc_new = init ? {x_s, 3'b000} : blend;
  wire [17:0]        rnd_new = {1'b0, acc_new} + `MIIR_HALF;
  wire [17:0]        rnd_old = {1'b0, a_s} + `MIIR_HALF;
  // Rounded to result width; fractions stay in the accumulator
  wire [13:0]        f_new   = rnd_new[16:3];
  wire [13:0]        f_old   = rnd_old[16:3];
  // Without an update the stored filter value is served as it stands
  wire [13:0]        fv      = x_load ? f_new : f_old;
  wire               ch_en   = is_filt ? channel_enable_cfg[fidx] : 1'b1;
  wire [13:0]        sel_v   = filtered_read_sel ? fv : x_s;
  wire [13:0]        alrt_v  = (is_filt && alert_source_sel) ? fv : x_s;

  // Transfer requests, highest priority first; ignored while busy
  wire               go_bal  = bal_meas_done;
  wire               go_end  = scan_end & ~double_buffer_en;
  wire               go_beg  = scan_start & double_buffer_en & pend;
  wire               go_mov  = move_req & ~result_ready_flag;
  wire               go_any  = go_bal | go_end | go_beg | go_mov;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                  <= ST_IDLE;
      ctrl                   <= `MIIR_CTRL_RST;
      channel_enable_cfg     <= `MIIR_CHEN_RST;
      acq_filter_preload     <= 1'b0;
      balance_filter_preload <= 1'b0;
      result_ready_flag      <= 1'b0;
      cal_off                <= 16'h0000;
      pend                   <= 1'b0;
      xch                    <= 5'h00;
      x_load                 <= 1'b0;
      x_stats                <= 1'b0;
      x_bal                  <= 1'b0;
      sum_acc                <= 18'h00000;
      cell_sum_result        <= 18'h00000;
      xfer_busy              <= 1'b0;
      alert_valid            <= 1'b0;
      alert_ch               <= 5'h00;
      alert_data             <= 14'h0000;
      for (i = 0; i < 17; i = i + 1) begin
        alu_mem[i] <= 14'h0000;
        res[i]     <= 14'h0000;
      end
      for (i = 0; i < 15; i = i + 1) begin
        acc[i] <= 17'h00000;
      end
    end else begin
      alert_valid <= 1'b0;
      if (alu_valid && (alu_ch <= `MIIR_CH_LAST) && (state == ST_IDLE)) begin
        alu_mem[alu_ch] <= alu_in;
      end
      if (scan_end && double_buffer_en) begin
        pend <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (go_any) begin
            state     <= ST_XFER;
            xfer_busy <= 1'b1;
            xch       <= 5'h00;
            sum_acc   <= 18'h00000;
            x_bal     <= go_bal;
            // Balancing loads regardless of the update bit
            x_load    <= go_bal | filter_update_en;
            // Out-of-scan moves leave the sum and alerts as they were
            x_stats   <= go_bal | go_end | go_beg;
            if (go_beg && !go_bal && !go_end) begin
              pend <= 1'b0;
            end
          end
        end
        ST_XFER: begin
          if (is_filt && ch_en && x_load) begin
            acc[fidx] <= acc_new;
          end
          if (!is_filt) begin
            res[xch] <= x_s;
          end else if (ch_en) begin
            res[xch] <= sel_v;
          end
          if ((xch < `MIIR_NCELL) && ch_en) begin
            sum_acc <= sum_acc + {4'h0, sel_v};
          end
          if (x_stats && ch_en) begin
            alert_valid <= 1'b1;
            alert_ch    <= xch;
            alert_data  <= alrt_v;
          end
          if (xch == `MIIR_CH_LAST) begin
            state <= ST_DONE;
          end else begin
            xch <= xch + 5'h01;
          end
        end
        ST_DONE: begin
          state     <= ST_IDLE;
          xfer_busy <= 1'b0;
          if (x_stats) begin
            cell_sum_result <= sum_acc;
          end
          // Preload acts once, then the filter continues
          if (x_load && x_bal) begin
            balance_filter_preload <= 1'b0;
          end
          if (x_load && !x_bal) begin
            acq_filter_preload <= 1'b0;
          end
        end
        default: begin
          state     <= ST_IDLE;
          xfer_busy <= 1'b0;
        end
      endcase
      // Software writes come after hardware clears of the preload bits
      if (wr_en && hi_ok) begin
        case (idx)
          `MIIR_IDX_CTRL: ctrl <= pwdata[7:0];
          `MIIR_IDX_CHEN: channel_enable_cfg <= pwdata[14:0];
          `MIIR_IDX_PRE: begin
            acq_filter_preload     <= pwdata[`MIIR_B_ACQ_PRE];
            balance_filter_preload <= pwdata[`MIIR_B_BAL_PRE];
          end
          `MIIR_IDX_STAT: begin
            if (!pwdata[`MIIR_B_RDY]) begin
              result_ready_flag <= 1'b0;
            end
          end
          `MIIR_IDX_CAL: cal_off <= pwdata[15:0];
          default: begin
          end
        endcase
      end
      // Hardware set is last so it wins over a clear in the same cycle
      if (state == ST_DONE) begin
        result_ready_flag <= 1'b1;
      end
    end
  end

  // Read mux
  always @* begin
    next_prdata = 32'h00000000;
    if (hi_ok) begin
      if ((idx >= `MIIR_IDX_CELL0) && (idx <= `MIIR_IDX_CELL13)) begin
        next_prdata = {18'h00000, res[cell_off[4:0]]};
      end else begin
        case (idx)
          `MIIR_IDX_CTRL:  next_prdata = {24'h000000, ctrl};
          `MIIR_IDX_CHEN:  next_prdata = {17'h00000, channel_enable_cfg};
          `MIIR_IDX_PRE:   next_prdata = {30'h00000000, balance_filter_preload, acq_filter_preload};
          `MIIR_IDX_STAT:  next_prdata = {29'h00000000, pend, xfer_busy, result_ready_flag};
          `MIIR_IDX_CAL:   next_prdata = {16'h0000, cal_off};
          `MIIR_IDX_BLOCK: next_prdata = {18'h00000, res[`MIIR_CH_BLK]};
          `MIIR_IDX_SUM:   next_prdata = {14'h0000, cell_sum_result};
          `MIIR_IDX_DIAGA: next_prdata = {18'h00000, res[`MIIR_CH_DIAGA]};
          `MIIR_IDX_DIAGB: next_prdata = {18'h00000, res[`MIIR_CH_DIAGB]};
          default:         next_prdata = 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc_ph & ~pready;
      pslverr <= acc_ph & ~pready & ~(hi_ok & mapped(idx));
      if (acc_ph && !pready && !pwrite) begin
        prdata <= (hi_ok & mapped(idx)) ? next_prdata : 32'h00000000;
      end
    end
  end

endmodule // miir_data_ctrl

// File: design/miir_defs.vh
// Constants for the measurement IIR data-control block.
// Assumes inclusion by the block's module and the bench; holds definitions only.
`ifndef MIIR_DEFS_VH
`define MIIR_DEFS_VH

// Register indices; byte address is four times the index
`define MIIR_IDX_CTRL      8'h01
`define MIIR_IDX_CHEN      8'h02
`define MIIR_IDX_PRE       8'h03
`define MIIR_IDX_STAT      8'h04
`define MIIR_IDX_CAL       8'h05
`define MIIR_IDX_CELL0     8'h20
`define MIIR_IDX_CELL13    8'h2D
`define MIIR_IDX_BLOCK     8'h55
`define MIIR_IDX_SUM       8'h56
`define MIIR_IDX_DIAGA     8'h57
`define MIIR_IDX_DIAGB     8'h58

// Control register fields
`define MIIR_B_UPD         0
`define MIIR_B_RDF         1
`define MIIR_B_ASRC        2
`define MIIR_B_DBL         3
`define MIIR_B_CAL         4
`define MIIR_B_COEF_LO     5
`define MIIR_B_COEF_HI     7
`define MIIR_CTRL_RST      8'h40

// Preload and status fields
`define MIIR_B_ACQ_PRE     0
`define MIIR_B_BAL_PRE     1
`define MIIR_B_RDY         0
`define MIIR_B_BUSY        1
`define MIIR_B_PEND        2

// Coefficient codes
`define MIIR_COEF_OFF      3'h7
`define MIIR_COEF_BAL      3'h0

// Channel map: 0..13 cells, 14 block, 15 and 16 diagnostics
`define MIIR_CHEN_RST      15'h7FFF
`define MIIR_NCELL         5'h0E
`define MIIR_CH_BLK        5'h0E
`define MIIR_CH_DIAGA      5'h0F
`define MIIR_CH_DIAGB      5'h10
`define MIIR_CH_LAST       5'h10

// Fraction bits held in the accumulator and rounding half step
`define MIIR_FRAC          3
`define MIIR_HALF          18'h00004
`define MIIR_RAW_MAX       18'h03FFF

`endif

// File: test/miir_data_ctrl_monitor.sv
// Port checker for the measurement data-control block.
// Assumes it is bound onto the block and sees only its ports.
`timescale 1ns/1ps
module miir_data_ctrl_monitor (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        bal_meas_done,
  input wire        xfer_busy,
  input wire        alert_valid,
  input wire [4:0]  alert_ch,
  input wire [13:0] alert_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("late pready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long pready");
  a_err_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
  a_read_load: assert property ($changed(prdata) |-> $past(psel) && $past(penable) && !$past(pwrite))
    else $error("prdata moved");
  a_busy_span: assert property ($rose(xfer_busy) |-> ##17 xfer_busy ##1 !xfer_busy)
    else $error("bad span");
  a_bal_take: assert property (bal_meas_done && !xfer_busy |=> xfer_busy)
    else $error("balance not taken");
  a_alert_busy: assert property (alert_valid |-> xfer_busy) else $error("stray alert");
  a_alert_order: assert property (alert_valid |=> !alert_valid || alert_ch > $past(alert_ch))
    else $error("alert order");
  a_alert_hold: assert property ($changed(alert_data) |-> alert_valid) else $error("alert data moved");
endmodule // miir_data_ctrl_monitor

bind miir_data_ctrl miir_data_ctrl_monitor i_miir_data_ctrl_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .bal_meas_done(bal_meas_done), .xfer_busy(xfer_busy),
  .alert_valid(alert_valid), .alert_ch(alert_ch), .alert_data(alert_data));

// File: test/miir_seq_model.sv
// Sequencer and ALU stand-in: one sample per channel, transfer events.
// Assumes the block's clock and its busy flag; diagnostic channels 15 and 16 take the same sample.
`timescale 1ns/1ps
module miir_seq_model (
  input  wire         pclk,
  input  wire         xfer_busy,
  output logic        alu_valid = 1'b0,
  output logic [4:0]  alu_ch = 5'h00,
  output logic [13:0] alu_raw = 14'h0000,
  output logic [3:0]  evt = 4'h0
);
  // Waits for idle, since the block drops samples during a transfer
  task automatic feed(input logic [13:0] v, input int gap);
    while (xfer_busy !== 1'b0) @(posedge pclk);
    for (int c = 0; c < 17; c++) begin
      @(posedge pclk);
      alu_valid <= 1'b1;
      alu_ch <= 5'(c);
      alu_raw <= v;
      @(posedge pclk);
      alu_valid <= 1'b0;
      alu_raw <= ~v;
      repeat (gap) @(posedge pclk);
    end
  endtask
  // Bits: 0 scan start, 1 scan end, 2 move, 3 balance done
  task automatic pulse(input int b);
    @(posedge pclk);
    evt[b] <= 1'b1;
    @(posedge pclk);
    evt <= 4'h0;
  endtask
endmodule // miir_seq_model

// File: test/tb_measurement_iir_data_control.sv
// Self-checking bench: APB tasks and the sequencer stand-in around the block.
// Assumes the bound port checker and the defs header on the include path.
`timescale 1ns/1ps
`include "miir_defs.vh"
module tb_measurement_iir_data_control;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic        pready, pslverr, xfer_busy, alert_valid, alu_valid, er;
  logic [4:0]  alert_ch, alu_ch;
  logic [13:0] alert_data, alu_raw, al0;
  logic [3:0]  evt;
  int          fails = 0, comparisons = 0, k, ex;

  miir_data_ctrl i_miir_data_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alu_valid(alu_valid), .alu_ch(alu_ch), .alu_raw(alu_raw), .scan_start(evt[0]), .scan_end(evt[1]),
    .move_req(evt[2]), .bal_meas_done(evt[3]), .xfer_busy(xfer_busy), .alert_valid(alert_valid),
    .alert_ch(alert_ch), .alert_data(alert_data));
  miir_seq_model i_miir_seq_model (.pclk(pclk), .xfer_busy(xfer_busy), .alu_valid(alu_valid),
    .alu_ch(alu_ch), .alu_raw(alu_raw), .evt(evt));

  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) if (alert_valid === 1'b1 && alert_ch === 5'h00) al0 <= alert_data;

  function automatic int fo(int a, int x, int c);
    return a + ((8 * x - a) * c >>> 3);
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, a, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rv, e);
  endtask
  task automatic ct(input logic [7:0] v);
    apb(1'b1, `MIIR_IDX_CTRL, {24'h0, v});
  endtask
  // Waits on busy; a hang is cut by the watchdog
  task automatic run(input int b);
    i_miir_seq_model.pulse(b);
    repeat (2) @(posedge pclk);
    while (xfer_busy !== 1'b0) @(posedge pclk);
    @(posedge pclk);
  endtask
  task automatic scan(input logic [13:0] v, input int g, input int b);
    i_miir_seq_model.feed(v, g);
    run(b);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    tally_and_finish;
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl", `MIIR_IDX_CTRL, 32'h40);
    rd("chen", `MIIR_IDX_CHEN, 32'h7FFF);
    rd("hole", 8'h7F, 32'h0);
    chk("err", {31'h0, er}, 32'h1);
    for (k = 0; k < 8; k++) begin
      ct({k[2:0], 5'h07});
      apb(1'b1, `MIIR_IDX_PRE, 32'h1);
      scan(14'h03E8, k, 1);
      rd("pre", `MIIR_IDX_PRE, 32'h0);
      scan(14'h0708, 0, 1);
      ex = (fo(8 * 'h3E8, 'h708, k + 1) + 4) >>> 3;
      rd("cell", `MIIR_IDX_CELL0, 32'(ex));
      chk("alert", 32'(al0), 32'(ex));
      rd("sum", `MIIR_IDX_SUM, 32'(14 * ex));
    end
    $display("test coefficients done");
    ct({3'h7, 5'h02});
    scan(14'h0BB8, 0, 1);
    rd("stale", `MIIR_IDX_CELL0, 32'h708);
    ct({3'h0, 5'h01});
    scan(14'h07D0, 0, 1);
    rd("raw", `MIIR_IDX_CELL0, 32'h7D0);
    ct({3'h0, 5'h02});
    apb(1'b1, `MIIR_IDX_STAT, 32'h0);
    run(2);
    rd("move", `MIIR_IDX_CELL0, 32'h721);
    rd("msum", `MIIR_IDX_SUM, 32'h6D60);
    ct({3'h0, 5'h00});
    run(2);
    rd("nomove", `MIIR_IDX_CELL0, 32'h721);
    ct({3'h7, 5'h0B});
    scan(14'h01F4, 0, 1);
    rd("dbl", `MIIR_IDX_CELL0, 32'h721);
    rd("stat", `MIIR_IDX_STAT, 32'h5);
    run(0);
    rd("dbl2", `MIIR_IDX_CELL0, 32'h1F4);
    $display("test data control done");
    ct({3'h7, 5'h02});
    scan(14'h0514, 0, 3);
    rd("bal", `MIIR_IDX_CELL0, 32'h258);
    rd("diag", `MIIR_IDX_DIAGA, 32'h514);
    chk("alraw", 32'(al0), 32'h514);
    apb(1'b1, `MIIR_IDX_CHEN, 32'h7FFE);
    ct({3'h7, 5'h03});
    scan(14'h0384, 0, 1);
    rd("off", `MIIR_IDX_CELL0, 32'h258);
    rd("on", `MIIR_IDX_CELL0 + 8'h01, 32'h384);
    rd("blk", `MIIR_IDX_BLOCK, 32'h384);
    rd("sum13", `MIIR_IDX_SUM, 32'h2DB4);
    apb(1'b1, `MIIR_IDX_CAL, 32'hFF9C);
    ct({3'h7, 5'h11});
    scan(14'h04B0, 1, 1);
    rd("cal", `MIIR_IDX_CELL0 + 8'h01, 32'h44C);
    $display("test balance and calibration done");
    tally_and_finish;
  end
endmodule // tb_measurement_iir_data_control
